// >>> hdl/eesi_pkg.sv
// Constants and carrier types shared by the serial EEPROM interface.
// Assumes a 10 MHz processor clock and a free-running engine clock.
package eesi_pkg;

  // Engine clock rate and serial clock rate, in hertz
  localparam int unsigned LINK_FREQ_HZ = 33_333_333;
  localparam int unsigned SCK_FREQ_HZ  = 78_000;
  // One serial clock period is four quarters; the quarter rounds down
  localparam int unsigned QUARTER_CYC  = LINK_FREQ_HZ / (4 * SCK_FREQ_HZ);
  localparam int unsigned QW           = 7;

  // Port-select codes
  localparam logic [1:0] SEL_OFF        = 2'h0;
  localparam logic [1:0] SEL_TWO_PIN    = 2'h1;
  localparam logic [1:0] SEL_THREE_WIRE = 2'h2;
  localparam logic [1:0] SEL_SPI        = 2'h3;

  // Byte layout and step sequencing
  localparam logic [3:0] BITS_BYTE       = 4'h8;
  localparam logic [3:0] BIT_MSB         = 4'h7;
  localparam logic [1:0] Q_SAMPLE        = 2'h2;
  localparam logic [5:0] STEP_FIRST      = 6'h00;
  localparam logic [5:0] STEP_LAST_START = 6'h01;
  localparam logic [5:0] STEP_LAST_STOP  = 6'h02;
  localparam logic [5:0] STEP_LAST_NINE  = 6'h23;
  localparam logic [5:0] STEP_LAST_EIGHT = 6'h1f;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_START = 3'h1,
    OP_TX    = 3'h2,
    OP_STOP  = 3'h3,
    OP_RX    = 3'h6
  } eesi_op_t;

  // Gray along idle, run, done
  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_RUN  = 2'h1,
    LS_DONE = 2'h3
  } eesi_lstate_t;

  // Value written to the serial control register
  typedef struct packed {
    eesi_op_t op;
    logic     ack_lvl;
  } eesi_ctrl_t;

  // One queued transfer: command, mode and byte snapshot
  typedef struct packed {
    eesi_op_t   op;
    logic       ack_lvl;
    logic [1:0] sel;
    logic [7:0] data;
  } eesi_cmd_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } eesi_pins_t;

  localparam eesi_pins_t PINS_RST = '{clk_o: 1'b1, clk_oe: 1'b0,
                                      dat_o: 1'b1, dat_oe: 1'b0};

  typedef struct packed {
    eesi_cmd_t  xfer;
    logic       req_tgl;
    logic       inflight;
    logic       done_s1;
    logic       done_s2;
    logic       done_seen;
    logic [7:0] data;
    logic       ack;
    logic       busy_q;
    logic       irq;
  } eesi_pstate_t;

  typedef struct packed {
    eesi_lstate_t  st;
    logic          req_s1;
    logic          req_s2;
    logic          req_seen;
    logic          done_tgl;
    logic [QW-1:0] qcnt;
    logic [5:0]    step;
    eesi_cmd_t     cmd;
    logic [7:0]    sh;
    logic          ack;
    eesi_pins_t    pins;
    logic          p3_s1;
    logic          p3_s2;
    logic          p8_s1;
    logic          p8_s2;
  } eesi_lst_t;

endpackage

// >>> hdl/eesi_pair_buf.sv
// Two-entry valid/ready buffer for queued transfer commands.
// Assumes both sides share one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module eesi_pair_buf #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,     // Processor clock
  input  wire logic         rst_n,     // Synchronous reset
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Offered word
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Drain side takes it
  output logic [W-1:0]      out_data   // Oldest word
);

  typedef struct packed {
    logic [1:0]   cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } eesi_buf_t;

  eesi_buf_t s_r;
  eesi_buf_t s_nxt;
  logic      push;
  logic      pop;

  assign in_ready  = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data  = s_r.e0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (pop) begin
      s_nxt.e0 = s_r.e1;
    end
    if (push) begin
      if (s_r.cnt == 2'h0 || (s_r.cnt == 2'h1 && pop)) begin
        s_nxt.e0 = in_data;
      end else begin
        s_nxt.e1 = in_data;
      end
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// >>> hdl/eesi_serial_if.sv
// Serial EEPROM interface: processor-side registers and a pin engine.
// Assumes pin inputs are asynchronous; link_clk runs free.
`timescale 1ns/10ps
module eesi_serial_if
  import eesi_pkg::*;
#(
  parameter int unsigned QUARTER = QUARTER_CYC
) (
  input  wire logic       clock,              // Processor clock, 10 MHz
  input  wire logic       rst_n,              // Synchronous reset
  input  wire logic       link_clk,           // Engine clock, free running
  input  wire logic [1:0] serial_port_select, // Mode select
  input  wire logic       data_wr,            // Load data register
  input  wire logic [7:0] data_in,            // Byte to load
  input  wire logic       control_wr,         // Write control register
  input  wire eesi_pkg::eesi_ctrl_t control_in, // Command and ack level
  output logic            control_ready,      // Command can be taken
  output logic [7:0]      serial_data_reg,    // Data register contents
  output logic            ack_received,       // Memory acknowledged
  output logic            busy,               // Transfer pending
  output logic            external_irq_five,  // Pulse one cycle after busy falls
  output logic            eeprom_clock_pin_o,  // Pin two level
  output logic            eeprom_clock_pin_oe, // Pin two driven
  output logic            eeprom_data_pin_o,   // Pin three level
  output logic            eeprom_data_pin_oe,  // Pin three driven
  input  wire logic       eeprom_data_pin_i,   // Pin three input
  input  wire logic       shared_pin_eight_i   // Pin eight input
);

  eesi_pstate_t p_r;
  eesi_pstate_t p_nxt;
  eesi_lst_t    l_r;
  eesi_lst_t    l_nxt;
  eesi_cmd_t    cmd_in;
  eesi_cmd_t    buf_out;
  logic         buf_valid;
  logic         buf_take;
  logic         lrst_s1;
  logic         lrst_s2;

  // Each command snapshots the data byte and mode it was issued with
  always_comb begin
    cmd_in.op      = control_in.op;
    cmd_in.ack_lvl = control_in.ack_lvl;
    cmd_in.sel     = serial_port_select;
    cmd_in.data    = data_wr ? data_in : p_r.data;
  end

  eesi_pair_buf #(.W($bits(eesi_cmd_t))) u_queue (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (control_wr),
    .in_ready  (control_ready),
    .in_data   (cmd_in),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_out)
  );

  assign buf_take = ~p_r.inflight;

  // Busy covers queued and running transfers
  assign busy              = buf_valid | p_r.inflight;
  assign serial_data_reg   = p_r.data;
  assign ack_received      = p_r.ack;
  assign external_irq_five = p_r.irq;

  always_comb begin
    p_nxt         = p_r;
    p_nxt.done_s1 = l_r.done_tgl;
    p_nxt.done_s2 = p_r.done_s1;
    p_nxt.busy_q  = busy;
    // One pulse in the cycle after busy falls
    p_nxt.irq     = p_r.busy_q & ~busy;
    // Writes while busy are ignored so a running byte is not overwritten
    if (data_wr && !busy) begin
      p_nxt.data = data_in;
    end
    if (buf_valid && !p_r.inflight) begin
      p_nxt.xfer     = buf_out;
      p_nxt.req_tgl  = ~p_r.req_tgl;
      p_nxt.inflight = 1'b1;
    end
    if (p_r.done_s2 != p_r.done_seen) begin
      p_nxt.done_seen = p_r.done_s2;
      p_nxt.inflight  = 1'b0;
      // Received byte lands in the data register
      if (p_r.xfer.op == OP_RX) begin
        p_nxt.data = l_r.sh;
      end
      // Acknowledge result of the transmitted byte
      if (p_r.xfer.op == OP_TX) begin
        p_nxt.ack = l_r.ack;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      p_r <= '0;
    end else begin
      p_r <= p_nxt;
    end
  end

  // Engine-domain reset, synchronised to link_clk
  always_ff @(posedge link_clk) begin
    lrst_s1 <= rst_n;
    lrst_s2 <= lrst_s1;
  end

  function automatic logic [5:0] last_step(eesi_cmd_t c);
    logic [5:0] r;
    r = STEP_FIRST;
    case (c.op)
      OP_START: r = STEP_LAST_START;
      OP_STOP:  r = STEP_LAST_STOP;
      OP_TX, OP_RX: begin
        r = (c.sel == SEL_TWO_PIN) ? STEP_LAST_NINE : STEP_LAST_EIGHT;
      end
      default: r = STEP_FIRST;
    endcase
    return r;
  endfunction

  // Pin levels for a given step of a command
  function automatic eesi_pins_t drive(eesi_cmd_t c, logic [5:0] s);
    eesi_pins_t p;
    logic       want;
    logic       drv;
    logic [3:0] b;
    b       = s[5:2];
    want    = 1'b1;
    drv     = 1'b1;
    p.clk_o = 1'b1;
    case (c.op)
      // Data falls while clock is high; repeats the same way
      OP_START: want = (s == STEP_FIRST);
      // Data rises while clock is high
      OP_STOP: begin
        p.clk_o = (s != STEP_FIRST);
        want    = (s == STEP_LAST_STOP);
      end
      // Shift out most significant bit first
      OP_TX: begin
        p.clk_o = s[1];
        if (b < BITS_BYTE) begin
          want = c.data[3'(BIT_MSB - b)];
        end else begin
          drv = 1'b0;
        end
      end
      // Release for data, then send chosen ack level
      OP_RX: begin
        p.clk_o = s[1];
        if (b < BITS_BYTE) begin
          drv = 1'b0;
        end else begin
          want = c.ack_lvl;
        end
      end
      default: p.clk_o = 1'b1;
    endcase
    p.clk_oe = (c.sel != SEL_OFF);
    case (c.sel)
      // Open drain: only ever pulls the data line low
      SEL_TWO_PIN: begin
        p.dat_o  = 1'b0;
        p.dat_oe = drv & ~want;
      end
      // Single shared data pin, released while receiving
      SEL_THREE_WIRE: begin
        p.dat_o  = want;
        p.dat_oe = drv;
      end
      // Pin three always driven, pin eight in; modes 0, 3
      SEL_SPI: begin
        p.dat_o  = want;
        p.dat_oe = 1'b1;
      end
      default: begin
        p.dat_o  = 1'b1;
        p.dat_oe = 1'b0;
      end
    endcase
    return p;
  endfunction

  always_comb begin
    l_nxt        = l_r;
    l_nxt.req_s1 = p_r.req_tgl;
    l_nxt.req_s2 = l_r.req_s1;
    l_nxt.p3_s1  = eeprom_data_pin_i;
    l_nxt.p3_s2  = l_r.p3_s1;
    l_nxt.p8_s1  = shared_pin_eight_i;
    l_nxt.p8_s2  = l_r.p8_s1;
    case (l_r.st)
      LS_IDLE: begin
        if (l_r.req_s2 != l_r.req_seen) begin
          // Command word is stable in the processor domain by now
          l_nxt.req_seen = l_r.req_s2;
          l_nxt.cmd      = p_r.xfer;
          l_nxt.step     = STEP_FIRST;
          l_nxt.qcnt     = '0;
          l_nxt.ack      = 1'b0;
          if (p_r.xfer.op == OP_NONE) begin
            l_nxt.st = LS_DONE;
          end else begin
            l_nxt.st   = LS_RUN;
            l_nxt.pins = drive(p_r.xfer, STEP_FIRST);
          end
        end
      end
      LS_RUN: begin
        // Four quarters per serial clock period gives 78kHz
        if (l_r.qcnt == QW'(QUARTER - 1)) begin
          l_nxt.qcnt = '0;
          if (l_r.step[1:0] == Q_SAMPLE) begin
            // Eight data bits sampled while clock is high
            if (l_r.cmd.op == OP_RX && l_r.step[5:2] < BITS_BYTE) begin
              l_nxt.sh = {l_r.sh[6:0],
                          (l_r.cmd.sel == SEL_SPI) ? l_r.p8_s2 : l_r.p3_s2};
            end
            // Low on the ninth bit means acknowledged
            if (l_r.cmd.op == OP_TX && l_r.step[5:2] == BITS_BYTE) begin
              l_nxt.ack = ~l_r.p3_s2;
            end
          end
          if (l_r.step == last_step(l_r.cmd)) begin
            // Last step leaves the clock high until the next transfer
            l_nxt.st = LS_DONE;
          end else begin
            l_nxt.step = l_r.step + 6'h01;
            l_nxt.pins = drive(l_r.cmd, l_r.step + 6'h01);
          end
        end else begin
          l_nxt.qcnt = l_r.qcnt + QW'(1);
        end
      end
      LS_DONE: begin
        // Completion crosses back as a toggle
        l_nxt.done_tgl = ~l_r.done_tgl;
        l_nxt.st       = LS_IDLE;
      end
      default: l_nxt.st = LS_IDLE;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2) begin
      l_r      <= '0;
      l_r.pins <= PINS_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign eeprom_clock_pin_o  = l_r.pins.clk_o;
  assign eeprom_clock_pin_oe = l_r.pins.clk_oe;
  assign eeprom_data_pin_o   = l_r.pins.dat_o;
  assign eeprom_data_pin_oe  = l_r.pins.dat_oe;

  sequence s_busy_fall;
    busy ##1 !busy;
  endsequence

  sequence s_rx_done;
    (p_r.done_s2 != p_r.done_seen) && (p_r.xfer.op == OP_RX);
  endsequence

  sequence s_start_low;
    (l_r.st == LS_RUN) && (l_r.cmd.op == OP_START)
      && (l_r.step == STEP_LAST_START);
  endsequence

  a_busy_on_cmd: assert property (@(posedge clock) disable iff (!rst_n)
    control_wr && control_ready |=> busy)
    else $error("busy did not rise after a command");

  a_irq_on_fall: assert property (@(posedge clock) disable iff (!rst_n)
    s_busy_fall |=> external_irq_five)
    else $error("no interrupt after busy fell");

  a_irq_only_fall: assert property (@(posedge clock) disable iff (!rst_n)
    external_irq_five |-> $past(busy, 2) && !$past(busy))
    else $error("interrupt without busy falling");

  a_rx_data_load: assert property (@(posedge clock) disable iff (!rst_n)
    s_rx_done |=> serial_data_reg == $past(l_r.sh))
    else $error("received byte not loaded");

  a_clk_idle_high: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    l_r.st == LS_IDLE |-> eeprom_clock_pin_o)
    else $error("serial clock not high between transfers");

  a_clk_on_quarter: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    $changed(eeprom_clock_pin_o) |-> l_r.qcnt == '0)
    else $error("serial clock moved off a quarter boundary");

  a_start_cond: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    s_start_low and (l_r.cmd.sel == SEL_TWO_PIN)
      |-> eeprom_clock_pin_o && eeprom_data_pin_oe && !eeprom_data_pin_o)
    else $error("start condition not held");

  a_tx_bit_level: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    l_r.st == LS_RUN && l_r.cmd.op == OP_TX && l_r.cmd.sel == SEL_TWO_PIN
      && l_r.step[5:2] < BITS_BYTE
      |-> eeprom_data_pin_oe == !l_r.cmd.data[3'(BIT_MSB - l_r.step[5:2])])
    else $error("transmitted bit level wrong");

  a_wire_rx_free: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    l_r.st == LS_RUN && l_r.cmd.op == OP_RX && l_r.cmd.sel == SEL_THREE_WIRE
      && l_r.step[5:2] < BITS_BYTE |-> !eeprom_data_pin_oe)
    else $error("data pin driven while receiving");

  a_spi_do_driven: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    l_r.st == LS_RUN && l_r.cmd.sel == SEL_SPI |-> eeprom_data_pin_oe)
    else $error("output pin not driven in SPI mode");

  a_tx_ack_take: assert property (@(posedge link_clk) disable iff (!lrst_s2)
    l_r.st == LS_RUN && l_r.cmd.op == OP_TX && l_r.step[5:2] == BITS_BYTE
      && l_r.step[1:0] == Q_SAMPLE && l_r.qcnt == QW'(QUARTER - 1)
      |=> l_r.ack == !$past(l_r.p3_s2))
    else $error("acknowledge not captured");

endmodule

// >>> verification/eesi_mem_model.sv
// Behavioural serial memory on the far side of the pin engine.
// Assumes the bench resolves the shared pins and pulses restart per byte.
`timescale 1ns/10ps
module eesi_mem_model (
  input  wire logic       scl,       // Resolved pin two
  input  wire logic       sda,       // Resolved pin three
  input  wire logic [1:0] sel,       // Port select in use
  input  wire logic       restart,   // Realign the bit count
  input  wire logic [7:0] send_byte, // Byte returned on reads
  input  wire logic       do_send,   // Drive read data
  input  wire logic       ack_en,    // Acknowledge written bytes
  output logic            m_o,       // Level driven
  output logic            m_oe,      // Driving its data line
  output logic [7:0]      mbyte,     // Last byte received
  output logic            ack_bit,   // Master ack level seen
  output int              nbytes,    // Bytes received
  output int              nstart,    // Start conditions seen
  output int              nstop      // Stop conditions seen
);
  int         cnt;
  int         i;
  int         j;
  int         nb;
  logic [7:0] sh;
  initial begin
    cnt = 0;
    nbytes = 0;
    nstart = 0;
    nstop = 0;
    m_oe = 1'b0;
    m_o = 1'b1;
  end
  assign nb = (sel == 2'h1) ? 9 : 8;
  always @(posedge restart) cnt = 0;
  // Conditions only mean something in two-pin mode; looked at a moment
  // later so data moving beside a falling clock is not taken for one
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0 && sel == 2'h1) begin
      nstart++;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b1 && sel == 2'h1)
      nstop++;
  end
  // Data moves while clock is low, read on rising edge
  always @(negedge scl) begin
    i = cnt % nb;
    cnt++;
    m_oe = 1'b0;
    if (i < 8 && do_send) begin
      m_oe = 1'b1;
      m_o = send_byte[7-i];
    end else if (i == 8 && ack_en) begin
      m_oe = 1'b1;
      m_o = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (cnt > 0) begin
      j = (cnt - 1) % nb;
      if (j < 8)
        sh = {sh[6:0], sda};
      if (j == 7) begin
        mbyte = sh;
        nbytes++;
      end
      if (j == 8)
        ack_bit = sda;
    end
  end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the serial EEPROM interface.
// Assumes the memory model file; pin three has a pull-up in two-pin mode.
`timescale 1ns/10ps
module testbench;
  import eesi_pkg::*;
  localparam int Q = 2;
  logic            clock, rst_n, link_clk, tog, restart;
  logic [1:0]      sel;
  logic            data_wr, control_wr, do_send, ack_en;
  logic [7:0]      data_in, send_byte, b;
  eesi_ctrl_t      control_in;
  wire logic       ready, busy, irq, ack, co, coe, dout, doe;
  wire logic       p2, p3, p8, m_o, m_oe, ack_bit;
  wire logic [7:0] dreg, mbyte;
  int              nbytes, nstart, nstop;
  int              miscompares, compares, seed, k, acc;
  real             tl, per;
  logic [7:0]      exp_q[$];
  eesi_serial_if #(.QUARTER(Q)) uut (.clock(clock), .rst_n(rst_n),
    .link_clk(link_clk), .serial_port_select(sel), .data_wr(data_wr),
    .data_in(data_in), .control_wr(control_wr), .control_in(control_in),
    .control_ready(ready), .serial_data_reg(dreg), .ack_received(ack),
    .busy(busy), .external_irq_five(irq), .eeprom_clock_pin_o(co),
    .eeprom_clock_pin_oe(coe), .eeprom_data_pin_o(dout),
    .eeprom_data_pin_oe(doe), .eeprom_data_pin_i(p3),
    .shared_pin_eight_i(p8));
  eesi_mem_model mem (.scl(p2), .sda(p3), .sel(sel), .restart(restart),
    .send_byte(send_byte), .do_send(do_send), .ack_en(ack_en), .m_o(m_o),
    .m_oe(m_oe), .mbyte(mbyte), .ack_bit(ack_bit), .nbytes(nbytes),
    .nstart(nstart), .nstop(nstop));
  assign p2 = coe ? co : tog;
  assign p3 = (sel == SEL_TWO_PIN) ? !((doe && !dout) || (m_oe && !m_o))
            : doe ? dout : (m_oe && sel == SEL_THREE_WIRE) ? m_o : tog;
  assign p8 = (m_oe && sel == SEL_SPI) ? m_o : tog;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(negedge clock) tog <= ~tog;
  always @(posedge p2) begin
    per = $realtime - tl;
    tl = $realtime;
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    chk("busy wait", 8'h01, {7'h0, n < 5000});
    @(negedge clock);
  endtask
  task automatic cmd(input eesi_op_t op, input logic al, input logic [7:0] d);
    @(negedge clock);
    data_wr = 1'b1;
    data_in = d;
    restart = 1'b1;
    @(negedge clock);
    data_wr = 1'b0;
    restart = 1'b0;
    control_wr = 1'b1;
    control_in = '{op: op, ack_lvl: al};
    @(negedge clock);
    control_wr = 1'b0;
    chk("busy set", 8'h01, {7'h0, busy});
    wait_idle();
    chk("irq pulse", 8'h01, {7'h0, irq});
    chk("clock idle", 8'h01, {7'h0, p2});
  endtask
  task automatic xfer(input logic [1:0] s, input eesi_op_t op,
                      input logic al);
    b = 8'($random(seed));
    sel = s;
    send_byte = b;
    do_send = (op == OP_RX);
    ack_en = (op == OP_TX) && al;
    cmd(op, al, b);
    if (op == OP_TX) begin
      exp_q.push_back(b);
      chk("byte at memory", exp_q.pop_front(), mbyte);
      chk("ack flag", {7'h0, al && s == SEL_TWO_PIN}, {7'h0, ack});
      chk("period", 8'h01, {7'h0, $rtoi(per + 0.5) == 4 * Q * 30});
    end else begin
      chk("read byte", b, dreg);
      if (s == SEL_TWO_PIN)
        chk("ack sent", {7'h0, al}, {7'h0, ack_bit});
    end
    do_send = 1'b0;
    ack_en = 1'b0;
    $display("test mode %0d op %0d done", s, op);
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    results();
  end
  initial begin
    {miscompares, compares, acc} = '0;
    seed = 12;
    tl = 0.0;
    per = 0.0;
    {rst_n, data_wr, control_wr, do_send, ack_en, restart, tog} = '0;
    sel = SEL_OFF;
    data_in = 8'h00;
    send_byte = 8'h00;
    control_in = '{op: OP_NONE, ack_lvl: 1'b0};
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    chk("reset flags", 8'h20, {2'h0, ready, busy, irq, ack, coe, doe});
    chk("reset data", 8'h00, dreg);
    // Software has mapped the shared pins to digital use
    sel = SEL_TWO_PIN;
    k = nstart;
    cmd(OP_START, 1'b0, 8'h00);
    xfer(SEL_TWO_PIN, OP_TX, 1'b1);
    xfer(SEL_TWO_PIN, OP_TX, 1'b0);
    xfer(SEL_TWO_PIN, OP_RX, 1'b0);
    xfer(SEL_TWO_PIN, OP_RX, 1'b1);
    cmd(OP_START, 1'b0, 8'h00);
    cmd(OP_STOP, 1'b0, 8'h00);
    chk("starts", 8'h02, 8'(nstart - k));
    chk("stops", 8'h01, 8'(nstop));
    for (int s = 2; s < 4; s++) begin
      xfer(2'(s), OP_TX, 1'b1);
      xfer(2'(s), OP_RX, 1'b0);
    end
    // Queue fill while the engine is still shifting the first byte
    sel = SEL_THREE_WIRE;
    b = 8'($random(seed));
    k = nbytes;
    @(negedge clock);
    data_wr = 1'b1;
    data_in = b;
    restart = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      data_wr = 1'b0;
      restart = 1'b0;
      control_wr = 1'b1;
      control_in = '{op: OP_TX, ack_lvl: 1'b0};
      if (ready === 1'b1) begin
        exp_q.push_back(b);
        acc++;
      end
    end
    @(negedge clock);
    control_wr = 1'b0;
    data_wr = 1'b1;
    data_in = ~b;
    @(negedge clock);
    data_wr = 1'b0;
    chk("refused", 8'h01, {7'h0, acc >= 2 && acc < 4});
    wait_idle();
    chk("bytes sent", 8'(acc), 8'(nbytes - k));
    chk("queued byte", exp_q[$], mbyte);
    chk("load while busy", b, dreg);
    $display("test queue done");
    results();
  end
endmodule
